// ### hw/oag_defines.svh
// register offsets, decode codes and step constants for the address generator
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH
`define OAG_OFF_CMD 8'h00
`define OAG_OFF_EXT 8'h04
`define OAG_OFF_PAGE 8'h08
`define OAG_OFF_BASE 8'h0c
`define OAG_OFF_WAIT 8'h10
`define OAG_OFF_ADDR 8'h14
`define OAG_OFF_OPND 8'h18
`define OAG_OFF_STAT 8'h1c
`define OAG_OFF_GPR 8'h20
`define OAG_OFF_GPR_END 8'h3c
`define OAG_M_DIRECT 4'ha
`define OAG_M_INDIR 4'hd
`define OAG_M_PREDEC 4'hb
`define OAG_M_POSTINC 4'hc
`define OAG_M_DISP8 4'he
`define OAG_M_DISP16 4'hf
`define OAG_M_ABS8 4'h0
`define OAG_M_ABS16 4'h1
`define OAG_ABS_LOW 3'h5
`define OAG_IMM8 8'h04
`define OAG_IMM16 8'h0c
`define OAG_SP_IDX 3'h7
`define OAG_STEP_BYTE 16'h0001
`define OAG_STEP_WORD 16'h0002
`define OAG_STATES_FAST 4'h2
`define OAG_STATES_SLOW 4'h3
`define OAG_ZERO_PAGE 8'h00
`define OAG_ZERO16 16'h0000
`define OAG_ZERO32 32'h00000000
`endif

// ### hw/oag_pkg.sv
// types shared by the operand address generator files
package oag_pkg;
  typedef enum logic [1:0] {CL_ONCHIP, CL_EXT2, CL_PERIPH, CL_EXT3} oag_class_e;
  typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_BUS} oag_state_e;
  typedef struct packed {
    logic [7:0] code_page_register;
    logic [7:0] stack_page_register;
    logic [7:0] extension_page_register;
    logic [7:0] data_page_register;
  } oag_pages_s;
  typedef struct packed {
    logic far_instr;
    logic pc_disp16;
    logic pc_relative;
    logic [7:0] ea_field;
  } oag_cmd_s;
  typedef struct packed {
    logic [3:0] states;
    oag_class_e bus_class;
    logic path16;
    logic word;
    logic is_mem;
    logic max_mode;
    logic invalid;
    logic addr_error;
    logic done;
    logic busy;
  } oag_status_s;
endpackage

// ### hw/oag_page_select.sv
// picks the upper address byte for register based data addresses
`timescale 1ns/10ps
module oag_page_select
  import oag_pkg::*;
(
  input wire logic [2:0] reg_sel, // selected general register
  input wire logic max_mode, // maximum mode active
  input wire oag_pkg::oag_pages_s pages, // page registers
  output logic [7:0] upper // address bits 23 to 16
);
  `include "oag_defines.svh"
  // pages apply only in maximum mode
  always_comb begin
    if (!max_mode) begin
      upper = `OAG_ZERO_PAGE;
    end else if (reg_sel[2:1] == 2'h3) begin
      upper = pages.stack_page_register;
    end else if (reg_sel[2:1] == 2'h2) begin
      upper = pages.extension_page_register;
    end else begin
      upper = pages.data_page_register;
    end
  end
endmodule

// ### hw/oag_bus_timer.sv
// counts the states of one bus cycle by access class
`timescale 1ns/10ps
module oag_bus_timer
  import oag_pkg::*;
#(
  parameter int WAIT_W = 2
) (
  input wire logic pclk, // system clock, one state per cycle
  input wire logic presetn, // async reset, active low
  input wire logic start, // begin a bus cycle
  input wire oag_pkg::oag_class_e bus_class, // access target class
  input wire logic [WAIT_W-1:0] waits, // inserted waits, slow region only
  output logic busy, // cycle in progress
  output logic done, // last state of the cycle
  output logic [3:0] states // total states of the cycle started last
);
  `include "oag_defines.svh"
  logic [3:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic [3:0] states_reg, states_next;
  logic [3:0] total;
  // state count by target; only the slow external region can wait
  always_comb begin
    total = `OAG_STATES_FAST;
    if (bus_class == CL_PERIPH) begin
      total = `OAG_STATES_SLOW;
    end else if (bus_class == CL_EXT3) begin
      total = `OAG_STATES_SLOW + 4'(waits);
    end
  end
  // load on start, count down, end on zero
  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    states_next = states_reg;
    if (start && !busy_reg) begin
      cnt_next = total - 4'h1;
      busy_next = 1'b1;
      states_next = total;
    end else if (busy_reg) begin
      if (cnt_reg == 4'h0) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 4'h1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      states_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      states_reg <= states_next;
    end
  end
  assign busy = busy_reg;
  assign done = busy_reg && (cnt_reg == 4'h0);
  assign states = states_reg;
endmodule

// ### hw/oag_top.sv
// operand address generator with its apb register file
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// - register fields: four mode bits, size bit, three register bits
// - register select code maps straight to register number zero to seven
// - pc relative mode comes from the opcode, one or two byte displacement
// - short absolute: zero, base register, extension byte
// - auto step is one for byte and two for word operands
// - stack pointer always steps by two
// - minimum mode drops page registers from address forming
// - branch target is code page above pc plus sign extended displacement
// - minimum mode confines addresses to 64 kbytes
// - minimum mode rejects the four far branch, call and return forms
// - maximum mode applies the page registers
// - maximum mode far branches and vectoring change the code page; there is no vectoring here, far branches and page register writes load it
// - one clock is one state; bus cycles last two or three states, plus any inserted waits in the slow region
// - on-chip memory: two states, 16-bit path
// - fast external region: 16-bit, two states, never waits
// - peripherals: three states, 8-bit path except timer words
// - slow external region may take inserted wait states
// - decrement before use; increment after use
// - displacement mode adds 8 or 16 bit displacement to the register
// - word or stack access at odd address is an address error
module oag_top
  import oag_pkg::*;
#(
  parameter logic [2:0] MIN_MODE_SEL = 3'h1,
  parameter logic [15:0] ONCHIP_LO = 16'h0000,
  parameter logic [15:0] ONCHIP_HI = 16'h7fff,
  parameter logic [15:0] PERIPH_LO = 16'hfe80,
  parameter logic [15:0] PERIPH_HI = 16'hffff,
  parameter logic [15:0] TIMER16_LO = 16'hfe80,
  parameter logic [15:0] TIMER16_HI = 16'hfebf,
  parameter logic [15:0] EXT2_LO = 16'h8000,
  parameter logic [15:0] EXT2_HI = 16'hbfff,
  parameter int WAIT_W = 2
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [2:0] mode_select_pins, // operating mode straps
  output logic [23:0] effective_address, // last formed address
  output logic bus_busy, // bus cycle running
  output logic bus_done, // last state of bus cycle
  output logic addr_error // odd word access seen
);
  import oag_pkg::*;
  `include "oag_defines.svh"

  oag_state_e st_reg, st_next;
  oag_cmd_s cmd_reg, cmd_next;
  logic [15:0] ext_reg, ext_next;
  oag_pages_s pages_reg, pages_next;
  logic [7:0] base_reg, base_next;
  logic [15:0] pc_reg, pc_next;
  logic [WAIT_W-1:0] wait_reg, wait_next;
  logic [15:0] gpr_reg [8];
  logic [15:0] gpr_next [8];
  logic [23:0] addr_reg, addr_next;
  logic [15:0] opnd_reg, opnd_next;
  oag_status_s stat_reg, stat_next;
  logic max_mode_reg, max_mode_next;
  logic strap_done_reg, strap_done_next;
  logic [31:0] prdata_reg, prdata_next;
  logic wr_acc, setup, hit;
  logic [31:0] rdata;
  logic [2:0] rsel;
  logic [3:0] mode;
  logic [15:0] cur, step, wb_val, disp8x;
  logic [7:0] reg_page;
  logic wb_en, is_mem, word, bad, far_ok, start;
  logic [23:0] ea;
  logic [15:0] opnd;
  oag_class_e cls;
  logic t_busy, t_done;
  logic [3:0] t_states;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_reg;

  // read mux and address decode
  always_comb begin
    hit = 1'b1;
    rdata = `OAG_ZERO32;
    if (paddr == `OAG_OFF_CMD) begin
      rdata = 32'(cmd_reg);
    end else if (paddr == `OAG_OFF_EXT) begin
      rdata = {16'h0000, ext_reg};
    end else if (paddr == `OAG_OFF_PAGE) begin
      rdata = pages_reg;
    end else if (paddr == `OAG_OFF_BASE) begin
      rdata = {pc_reg, 8'h00, base_reg};
    end else if (paddr == `OAG_OFF_WAIT) begin
      rdata = 32'(wait_reg);
    end else if (paddr == `OAG_OFF_ADDR) begin
      rdata = {8'h00, addr_reg};
    end else if (paddr == `OAG_OFF_OPND) begin
      rdata = {16'h0000, opnd_reg};
    end else if (paddr == `OAG_OFF_STAT) begin
      rdata = 32'(stat_reg);
    end else if (paddr >= `OAG_OFF_GPR && paddr <= `OAG_OFF_GPR_END &&
                 paddr[1:0] == 2'h0) begin
      rdata = {16'h0000, gpr_reg[paddr[4:2]]};
    end else begin
      hit = 1'b0;
    end
  end

  // field split of the effective address byte
  assign mode = cmd_reg.ea_field[7:4];
  assign rsel = cmd_reg.ea_field[2:0];
  assign cur = gpr_reg[rsel];
  assign disp8x = {{8{ext_reg[7]}}, ext_reg[7:0]};

  oag_page_select u_page (
    .reg_sel(rsel),
    .max_mode(max_mode_reg),
    .pages(pages_reg),
    .upper(reg_page)
  );

  // address and operand forming for all eight modes
  always_comb begin
    ea = addr_reg;
    opnd = `OAG_ZERO16;
    is_mem = 1'b0;
    bad = 1'b0;
    wb_en = 1'b0;
    wb_val = cur;
    word = cmd_reg.ea_field[3];
    // stack pointer steps are always word sized
    step = word ? `OAG_STEP_WORD : `OAG_STEP_BYTE;
    if (rsel == `OAG_SP_IDX) begin
      step = `OAG_STEP_WORD;
    end
    if (cmd_reg.pc_relative) begin
      // mode comes from the opcode, no field decode here
      word = 1'b0;
      ea[15:0] = pc_reg + (cmd_reg.pc_disp16 ? ext_reg : disp8x);
      ea[23:16] = max_mode_reg ? pages_reg.code_page_register
                               : `OAG_ZERO_PAGE;
    end else if (cmd_reg.ea_field == `OAG_IMM8) begin
      opnd = {8'h00, ext_reg[7:0]};
      word = 1'b0;
    end else if (cmd_reg.ea_field == `OAG_IMM16) begin
      opnd = ext_reg;
      word = 1'b1;
    end else if (mode == `OAG_M_ABS8 && rsel == `OAG_ABS_LOW) begin
      ea = {`OAG_ZERO_PAGE, base_reg, ext_reg[7:0]};
      is_mem = 1'b1;
    end else if (mode == `OAG_M_ABS16 && rsel == `OAG_ABS_LOW) begin
      ea = {max_mode_reg ? pages_reg.data_page_register
                         : `OAG_ZERO_PAGE, ext_reg};
      is_mem = 1'b1;
    end else if (mode == `OAG_M_DIRECT) begin
      opnd = word ? cur : {8'h00, cur[7:0]};
    end else if (mode == `OAG_M_INDIR) begin
      ea = {reg_page, cur};
      is_mem = 1'b1;
    end else if (mode == `OAG_M_PREDEC) begin
      wb_val = cur - step;
      ea = {reg_page, wb_val};
      wb_en = 1'b1;
      is_mem = 1'b1;
    end else if (mode == `OAG_M_POSTINC) begin
      ea = {reg_page, cur};
      wb_val = cur + step;
      wb_en = 1'b1;
      is_mem = 1'b1;
    end else if (mode == `OAG_M_DISP8) begin
      ea = {reg_page, cur + disp8x};
      is_mem = 1'b1;
    end else if (mode == `OAG_M_DISP16) begin
      ea = {reg_page, cur + ext_reg};
      is_mem = 1'b1;
    end else begin
      bad = 1'b1;
    end
    if ((mode == `OAG_M_PREDEC || mode == `OAG_M_POSTINC) &&
        rsel == `OAG_SP_IDX && !cmd_reg.pc_relative) begin
      word = 1'b1;
    end
  end

  // far forms are only legal when pages exist
  assign far_ok = !cmd_reg.far_instr || max_mode_reg;

  // target class from the in-page address
  always_comb begin
    cls = CL_EXT3;
    if (ea[15:0] >= PERIPH_LO && ea[15:0] <= PERIPH_HI) begin
      cls = CL_PERIPH;
    end else if (ea[15:0] >= ONCHIP_LO && ea[15:0] <= ONCHIP_HI) begin
      cls = CL_ONCHIP;
    end else if (ea[15:0] >= EXT2_LO && ea[15:0] <= EXT2_HI) begin
      cls = CL_EXT2;
    end
  end

  // odd word accesses never reach the bus
  assign start = (st_reg == ST_DECODE) && is_mem && far_ok && !bad &&
                 !(word && ea[0]);

  oag_bus_timer #(.WAIT_W(WAIT_W)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(start),
    .bus_class(cls),
    .waits(cls == CL_EXT3 ? wait_reg : '0),
    .busy(t_busy),
    .done(t_done),
    .states(t_states)
  );

  // control, register file and sequencing
  always_comb begin
    st_next = st_reg;
    cmd_next = cmd_reg;
    ext_next = ext_reg;
    pages_next = pages_reg;
    base_next = base_reg;
    pc_next = pc_reg;
    wait_next = wait_reg;
    gpr_next = gpr_reg;
    addr_next = addr_reg;
    opnd_next = opnd_reg;
    stat_next = stat_reg;
    prdata_next = setup ? rdata : prdata_reg;
    // mode pins are caught once, the first cycle after reset release
    max_mode_next = max_mode_reg;
    strap_done_next = 1'b1;
    if (!strap_done_reg) begin
      max_mode_next = (mode_select_pins != MIN_MODE_SEL);
    end
    stat_next.max_mode = max_mode_reg;
    stat_next.states = t_states;
    // pages change only by software writes or far branches
    if (wr_acc && paddr == `OAG_OFF_PAGE) begin
      pages_next = pwdata;
    end
    if (wr_acc && paddr == `OAG_OFF_EXT) begin
      ext_next = pwdata[15:0];
    end
    if (wr_acc && paddr == `OAG_OFF_BASE) begin
      base_next = pwdata[7:0];
      pc_next = pwdata[31:16];
    end
    if (wr_acc && paddr == `OAG_OFF_WAIT) begin
      wait_next = pwdata[WAIT_W-1:0];
    end
    if (wr_acc && paddr >= `OAG_OFF_GPR && paddr <= `OAG_OFF_GPR_END &&
        paddr[1:0] == 2'h0) begin
      gpr_next[paddr[4:2]] = pwdata[15:0];
    end
    case (st_reg)
      ST_IDLE: begin
        // commands while busy are dropped
        if (wr_acc && paddr == `OAG_OFF_CMD) begin
          cmd_next = pwdata[10:0];
          st_next = ST_DECODE;
          stat_next.busy = 1'b1;
          stat_next.done = 1'b0;
        end
      end
      ST_DECODE: begin
        addr_next = ea;
        opnd_next = opnd;
        stat_next.is_mem = is_mem;
        stat_next.word = word;
        stat_next.bus_class = cls;
        stat_next.path16 = (cls != CL_PERIPH) ||
          (ea[15:0] >= TIMER16_LO && ea[15:0] <= TIMER16_HI);
        stat_next.invalid = bad || !far_ok;
        stat_next.addr_error = is_mem && word && ea[0];
        if (cmd_reg.far_instr && max_mode_reg) begin
          pages_next.code_page_register = ext_reg[7:0];
        end
        if (wb_en && !(word && ea[0])) begin
          gpr_next[rsel] = wb_val;
        end
        if (start) begin
          st_next = ST_BUS;
        end else begin
          st_next = ST_IDLE;
          stat_next.busy = 1'b0;
          stat_next.done = 1'b1;
        end
      end
      ST_BUS: begin
        if (t_done) begin
          st_next = ST_IDLE;
          stat_next.busy = 1'b0;
          stat_next.done = 1'b1;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_IDLE;
      cmd_reg <= '0;
      ext_reg <= `OAG_ZERO16;
      pages_reg <= '0;
      base_reg <= `OAG_ZERO_PAGE;
      pc_reg <= `OAG_ZERO16;
      wait_reg <= '0;
      for (int i = 0; i < 8; i++) begin
        gpr_reg[i] <= `OAG_ZERO16;
      end
      addr_reg <= 24'h000000;
      opnd_reg <= `OAG_ZERO16;
      stat_reg <= '0;
      max_mode_reg <= 1'b0;
      strap_done_reg <= 1'b0;
      prdata_reg <= `OAG_ZERO32;
    end else begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      ext_reg <= ext_next;
      pages_reg <= pages_next;
      base_reg <= base_next;
      pc_reg <= pc_next;
      wait_reg <= wait_next;
      gpr_reg <= gpr_next;
      addr_reg <= addr_next;
      opnd_reg <= opnd_next;
      stat_reg <= stat_next;
      max_mode_reg <= max_mode_next;
      strap_done_reg <= strap_done_next;
      prdata_reg <= prdata_next;
    end
  end

  assign effective_address = addr_reg;
  assign bus_busy = t_busy;
  assign bus_done = t_done;
  assign addr_error = stat_reg.addr_error;

  // checks on the decode and bus timing
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_min_page;
    st_reg == ST_DECODE && !max_mode_reg && !cmd_reg.far_instr |=>
      addr_reg[23:16] == 8'h00;
  endproperty
  a_min_page: assert property (p_min_page) else $error("page used in min");
  property p_far_bad;
    st_reg == ST_DECODE && cmd_reg.far_instr && !max_mode_reg |=>
      stat_reg.invalid && st_reg == ST_IDLE;
  endproperty
  a_far_bad: assert property (p_far_bad) else $error("far not rejected");
  property p_sp_step;
    st_reg == ST_DECODE && wb_en && rsel == `OAG_SP_IDX &&
      !(word && ea[0]) |=>
      gpr_reg[7] == ($past(cur) + (($past(mode) == `OAG_M_PREDEC) ?
        16'hfffe : 16'h0002));
  endproperty
  a_sp_step: assert property (p_sp_step) else $error("sp step wrong");
  property p_byte_step;
    st_reg == ST_DECODE && mode == `OAG_M_POSTINC && !cmd_reg.ea_field[3] &&
      rsel != `OAG_SP_IDX && !cmd_reg.pc_relative |=>
      gpr_reg[$past(rsel)] == $past(cur) + 16'h0001;
  endproperty
  a_byte_step: assert property (p_byte_step) else $error("byte step");
  property p_short_abs;
    st_reg == ST_DECODE && !cmd_reg.pc_relative && mode == `OAG_M_ABS8 &&
      rsel == `OAG_ABS_LOW |=>
      addr_reg == {8'h00, $past(base_reg), $past(ext_reg[7:0])};
  endproperty
  a_short_abs: assert property (p_short_abs) else $error("short abs");
  property p_odd_word;
    st_reg == ST_DECODE && is_mem && word && ea[0] |=>
      addr_error && !t_busy;
  endproperty
  a_odd_word: assert property (p_odd_word) else $error("odd word");
  property p_fast_cycle;
    start && (cls == CL_ONCHIP || cls == CL_EXT2) |-> !t_done ##2 t_done;
  endproperty
  a_fast_cycle: assert property (p_fast_cycle) else $error("2 state");
  property p_periph_cycle;
    start && cls == CL_PERIPH |-> !t_done ##1 !t_done ##2 t_done;
  endproperty
  a_periph_cycle: assert property (p_periph_cycle) else $error("3 state");
  property p_slow_cycle;
    start && cls == CL_EXT3 |-> ##[3:6] t_done;
  endproperty
  a_slow_cycle: assert property (p_slow_cycle) else $error("slow cycle");
  property p_pcrel;
    st_reg == ST_DECODE && cmd_reg.pc_relative && !cmd_reg.pc_disp16 |=>
      addr_reg[15:0] == $past(pc_reg) + {{8{$past(ext_reg[7])}},
        $past(ext_reg[7:0])};
  endproperty
  a_pcrel: assert property (p_pcrel) else $error("pc relative");
  c_postinc: cover property (st_reg == ST_DECODE && mode == `OAG_M_POSTINC);
  c_far: cover property (st_reg == ST_DECODE && cmd_reg.far_instr &&
    max_mode_reg);
  c_slow_wait: cover property (start && cls == CL_EXT3 && wait_reg != '0);
  c_odd: cover property (stat_reg.addr_error);
endmodule

// ### verification/oag_strap_model.sv
// strap model that sets the operating mode on the mode pins
`timescale 1ns/10ps
module oag_strap_model #(
  parameter logic [2:0] MIN_SEL = 3'h1
) (
  input wire logic want_min, // ask for minimum mode
  output logic [2:0] mode_select_pins // straps toward the block
);
  // straps stay put; any code but MIN_SEL gives maximum mode
  assign mode_select_pins = want_min ? MIN_SEL : ~MIN_SEL;
endmodule

// ### verification/testbench.sv
// self-checking bench for the operand address generator
`timescale 1ns/10ps
`include "oag_defines.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, chk_on, want_min;
  logic pready, pslverr, bus_busy, bus_done, addr_error;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] mode_select_pins;
  logic [23:0] effective_address;
  logic [32:0] exp_q[$], msk_q[$];
  logic [7:0] nam_q[$];
  logic [15:0] gv[8];
  logic [15:0] rnd;
  int err_total, total_checks, busy_cyc, done_cyc;

  oag_top oag_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_select_pins(mode_select_pins),
    .effective_address(effective_address), .bus_busy(bus_busy),
    .bus_done(bus_done), .addr_error(addr_error));
  oag_strap_model oag_strap_model_inst (.want_min(want_min),
    .mode_select_pins(mode_select_pins));

  // 200 MHz state clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic cmp(input logic [7:0] nm, input logic [32:0] e, m, g);
    total_checks++;
    if (((g ^ e) & m) !== 33'h0) begin
      err_total++;
      $display("Error reg %h expected %h seen %h", nm, e & m, g & m);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; the idle edge first keeps each signal single-driven
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic c);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk_on <= c;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_on <= 1'b0;
    if (n >= 20) begin
      err_total++;
      wrap_up();
    end
  endtask

  // checked reads land here in issue order
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && chk_on && exp_q.size() > 0) begin
      cmp(nam_q.pop_front(), exp_q.pop_front(), msk_q.pop_front(),
        {pslverr, prdata});
    end
  end

  // bus cycle length and end pulses as seen on the pins
  always @(posedge pclk) begin
    if (bus_busy === 1'b1) begin
      busy_cyc++;
    end
    if (bus_done === 1'b1) begin
      done_cyc++;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [32:0] e, m);
    nam_q.push_back(a);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0, 1'b1);
  endtask

  task automatic set_gpr(input logic [2:0] n, input logic [15:0] v);
    wr(`OAG_OFF_GPR + {3'h0, n, 2'b0}, {16'h0, v});
  endtask

  task automatic do_reset(input logic m);
    @(posedge pclk);
    want_min <= m;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  // issue a command, then poll status; a new command waits for idle
  task automatic cmd(input logic [10:0] c, input logic [15:0] x);
    int n;
    wr(`OAG_OFF_EXT, {16'h0, x});
    wr(`OAG_OFF_CMD, {21'h0, c});
    n = 0;
    rd = 32'h0;
    while (rd[1:0] !== 2'b10 && n < 40) begin
      apb(1'b0, `OAG_OFF_STAT, 32'h0, 1'b0);
      n++;
    end
    if (n >= 40) begin
      err_total++;
      wrap_up();
    end
  endtask

  // f holds max mode, invalid and address error flags
  task automatic expect_ea(input logic [23:0] a, input logic [2:0] f,
      input logic ac);
    if (ac) begin
      rd_chk(`OAG_OFF_ADDR, {9'h0, a}, 33'hffffff);
      cmp(8'hfe, {9'h0, a}, 33'hffffff, {9'h0, effective_address});
    end
    rd_chk(`OAG_OFF_STAT, {28'h0, f, 2'b10}, 33'h1f);
    cmp(8'hff, {32'h0, f[0]}, 33'h1, {32'h0, addr_error});
  endtask

  task automatic ea(input logic [10:0] c, input logic [15:0] x,
      input logic [23:0] a);
    cmd(c, x);
    expect_ea(a, 3'b100, 1'b1);
  endtask

  task automatic step(input logic [7:0] c, input logic [23:0] a,
      input logic [2:0] n, input logic [15:0] v);
    ea({3'b0, c}, 16'h0, a);
    rd_chk(`OAG_OFF_GPR + {3'h0, n, 2'b0}, {17'h0, v}, 33'hffff);
  endtask

  task automatic opn(input logic [10:0] c, input logic [15:0] x, v);
    cmd(c, x);
    rd_chk(`OAG_OFF_OPND, {17'h0, v}, 33'hffff);
    expect_ea(24'h0, 3'b100, 1'b0);
  endtask

  // status bits 13:7 carry states, class and path width
  task automatic tim(input logic [15:0] a, input logic [3:0] s,
      input logic [1:0] c, input logic p, pc);
    int b0, d0;
    set_gpr(3'd2, a);
    b0 = busy_cyc;
    d0 = done_cyc;
    cmd(11'h0da, 16'h0);
    rd_chk(`OAG_OFF_STAT, {19'h0, s, c, p, 7'h0},
      {19'h0, 4'hf, 2'h3, pc, 7'h0});
    cmp(8'hfd, 33'(s), 33'hf, 33'(busy_cyc - b0));
    cmp(8'hfc, 33'h1, 33'hff, 33'(done_cyc - d0));
  endtask

  // maximum mode first, then a second reset into minimum mode
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chk_on = 1'b0;
    want_min = 1'b0;
    err_total = 0;
    total_checks = 0;
    gv = '{16'h1000, 16'h3000, 16'h1234, 16'h2000, 16'h0100, 16'h0500,
      16'h0600, 16'h4000};
    rnd = 16'($urandom(19174));
    do_reset(1'b0);
    wr(`OAG_OFF_PAGE, 32'h44332211);
    wr(`OAG_OFF_BASE, 32'h10000056);
    wr(`OAG_OFF_WAIT, 32'h2);
    for (int i = 0; i < 8; i++) begin
      set_gpr(3'(i), gv[i]);
    end
    for (int i = 0; i < 8; i++) begin
      ea({6'h1b, 3'(i)}, 16'h0, {i > 5 ? 8'h33 : i > 3 ? 8'h22 : 8'h11,
        gv[i]});
    end
    cmd(11'h4da, 16'h0066);
    rd_chk(`OAG_OFF_PAGE, 33'h066000000, 33'h0ff000000);
    step(8'hbb, 24'h111ffe, 3'd3, 16'h1ffe);
    step(8'hc1, 24'h113000, 3'd1, 16'h3001);
    step(8'hc7, 24'h334000, 3'd7, 16'h4002);
    step(8'hb7, 24'h334000, 3'd7, 16'h4000);
    step(8'hb6, 24'h3305ff, 3'd6, 16'h05ff);
    ea(11'h0e8, 16'h0010, 24'h111010);
    ea(11'h0fc, 16'h0200, 24'h220300);
    ea(11'h005, 16'h0078, 24'h005678);
    ea(11'h015, 16'habcd, 24'h11abcd);
    wr(`OAG_OFF_PAGE, 32'h66332255);
    ea(11'h015, 16'habcd, 24'h55abcd);
    ea(11'h100, 16'h00f0, 24'h660ff0);
    ea(11'h300, 16'h0200, 24'h661200);
    opn(11'h00c, rnd, rnd);
    opn(11'h004, 16'h0012, 16'h0012);
    opn(11'h0ab, 16'h0, 16'h1ffe);
    cmd(11'h020, 16'h0);
    expect_ea(24'h0, 3'b110, 1'b0);
    set_gpr(3'd2, 16'h1235);
    cmd(11'h0da, 16'h0);
    expect_ea(24'h0, 3'b101, 1'b0);
    set_gpr(3'd7, 16'h4001);
    cmd(11'h0c7, 16'h0);
    expect_ea(24'h0, 3'b101, 1'b0);
    rd_chk(`OAG_OFF_GPR + 8'h1c, 33'h4001, 33'hffff);
    tim(16'h1234, 4'h2, 2'd0, 1'b1, 1'b1);
    tim(16'h9000, 4'h2, 2'd1, 1'b1, 1'b1);
    tim(16'hff00, 4'h3, 2'd2, 1'b0, 1'b1);
    tim(16'hfe90, 4'h3, 2'd2, 1'b1, 1'b1);
    tim(16'hc000, 4'h5, 2'd3, 1'b0, 1'b0);
    wr(`OAG_OFF_WAIT, 32'h0);
    tim(16'hc000, 4'h3, 2'd3, 1'b0, 1'b0);
    // an unmapped offset answers with an error and zero data
    rd_chk(8'h40, {1'b1, 32'h0}, {33{1'b1}});
    do_reset(1'b1);
    set_gpr(3'd2, 16'h1234);
    wr(`OAG_OFF_PAGE, 32'h44332211);
    cmd(11'h0da, 16'h0);
    expect_ea(24'h001234, 3'b000, 1'b1);
    cmd(11'h4da, 16'h0066);
    expect_ea(24'h0, 3'b010, 1'b0);
    wrap_up();
  end
endmodule
